/* ssa_defines.svh */
`ifndef SSA_DEFINES_SVH
`define SSA_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define SSA_RESULT_W         8
`define SSA_MUX_W            4
`define SSA_CNT_W            4

// ----------------------------------------------------------------------
// Sequencing counts
// ----------------------------------------------------------------------
`define SSA_LAST_RESULT_BIT  4'h7
`define SSA_LSB_SHIFTS       4'h7
`define SSA_TRIAL_START      8'h80
`define SSA_SE_CHANNELS      8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
// Pin order {cs_n, sclk, di, se_n, cmp}; deselected and shift-enable idle
`define SSA_PINS_RESET       5'h12
`define SSA_ZERO_BYTE        8'h00
`define SSA_ZERO_NIBBLE      4'h0

`endif

/* ssa_pkg.sv */
`include "ssa_defines.svh"

package ssa_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SSA_IDLE     = 3'b000,
        SSA_ADDR     = 3'b001,
        SSA_SETTLE   = 3'b010,
        SSA_CONV     = 3'b011,
        SSA_HOLD_LSB = 3'b100,
        SSA_LSB_OUT  = 3'b101,
        SSA_DONE_LOW = 3'b110
    } ssa_state_type;

    // ------------------------------------------------------------------
    // Channel assignment word, left justified
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       single_or_diff_bit;
        logic       odd_sign_bit;
        logic [1:0] select_bits;
    } ssa_mux_type;

    // ------------------------------------------------------------------
    // Pins that arrive from outside the clock domain
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic serial_input;
        logic lsb_order_enable_n;
        logic comparator_high;
    } ssa_pins_type;

    typedef struct packed {
        ssa_pins_type meta;
        ssa_pins_type stable;
    } ssa_sync_regs_type;

    // ------------------------------------------------------------------
    // Whole state of the serial controller
    // ------------------------------------------------------------------
    typedef struct packed {
        ssa_state_type                state;
        logic                         sclk_prev;
        logic [`SSA_MUX_W-1:0]        addr;
        logic [`SSA_CNT_W-1:0]        cnt;
        logic                         busy;
        logic                         do_bit;
        logic                         do_en_n;
        logic [`SSA_RESULT_W-1:0]     trial;
        logic [`SSA_RESULT_W-1:0]     result;
        logic [`SSA_RESULT_W-1:0]     out_sreg;
        ssa_mux_type                  mux;
        logic                         sample_pos;
        logic                         sample_neg;
        logic                         cmp_strobe;
    } ssa_regs_type;

endpackage

/* ssa_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module ssa_sync
    import ssa_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire ssa_pins_type pins_async,
    output var  ssa_pins_type pins_sync
);

    ssa_sync_regs_type q;
    ssa_sync_regs_type d;

    // ------------------------------------------------------------------
    // Two-stage synchroniser; only the second stage leaves the module
    // ------------------------------------------------------------------
    always_comb begin
        d        = q;
        d.meta   = pins_async;
        d.stable = q.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= {`SSA_PINS_RESET, `SSA_PINS_RESET};
        end else begin
            q <= d;
        end
    end

    assign pins_sync = q.stable;

endmodule // ssa_sync

`default_nettype wire

/* ssa_serial_ctrl.sv */
// Function
// - Shift serial input on each rising clock
// - Ignore leading zeros; first one starts
// - Capture two to four assignment bits
// - Half-clock settling after start and assignment bits placed
// - Raise busy, stop accepting serial input
// - Output leaves high-z, drives leading zero
// - Comparator decisions out on falling edges, MSB
// - Eight periods; busy drops half clock later
// - Keep all result bits in shift register
// - Without shift enable, LSB-first follows automatically
// - After LSB stream output low until deselect
// - Shift enable high holds LSB on output
// - Shift enable low clocks out LSB first
// - Single-input variant outputs MSB-first only
// - Chip select high clears all sequencer registers but sclk_prev
// - Serial input looked at only for the start bit and while addressing
// - Sample positive, then negative half clock later
// - Comparator strobed at end of period
// - Result is unsigned eight-bit code
// - First bit single/diff, then odd/sign, select
// - Single-input variant needs no assignment bits
`timescale 1ns/1ps
`default_nettype none

`include "ssa_defines.svh"

module ssa_serial_ctrl
    import ssa_pkg::*;
#(
    parameter int MUX_CHANNELS = 8
)
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      chip_select_n,
    input  wire logic                      serial_clk,
    input  wire logic                      serial_input,
    input  wire logic                      lsb_order_enable_n,
    input  wire logic                      comparator_high,
    output var  logic                      conversion_busy,
    output var  logic                      serial_out_data,
    output var  logic                      serial_out_en_n,
    output var  ssa_mux_type               mux_assign,
    output var  logic [`SSA_RESULT_W-1:0]  dac_trial_code,
    output var  logic [`SSA_RESULT_W-1:0]  result_code,
    output var  logic                      sample_pos_strobe,
    output var  logic                      sample_neg_strobe,
    output var  logic                      comparator_strobe
);

    // ------------------------------------------------------------------
    // Variant shape
    // ------------------------------------------------------------------
    localparam int  ADDR_W  = (MUX_CHANNELS == 8) ? 4 :
                              (MUX_CHANNELS == 4) ? 3 :
                              (MUX_CHANNELS == 2) ? 2 : 0;
    localparam bit  HAS_SE  = (MUX_CHANNELS == `SSA_SE_CHANNELS);
    localparam bit  MSB_ONLY = (MUX_CHANNELS == 1);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    ssa_pins_type pins_async;
    ssa_pins_type pins;

    assign pins_async = '{cs_n:               chip_select_n,
                          sclk:               serial_clk,
                          serial_input:       serial_input,
                          lsb_order_enable_n: lsb_order_enable_n,
                          comparator_high:    comparator_high};

    ssa_sync u_sync (
        .clk        (clk),
        .reset_n    (reset_n),
        .pins_async (pins_async),
        .pins_sync  (pins)
    );

    ssa_regs_type q;
    ssa_regs_type d;

    logic sclk_rise;
    logic sclk_fall;

    // The converter clock is oversampled; it must stay well below clk/4
    assign sclk_rise = pins.sclk & ~q.sclk_prev;
    assign sclk_fall = ~pins.sclk & q.sclk_prev;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0]                bit_idx;
        logic [`SSA_MUX_W-1:0]     addr_next;
        bit_idx       = 3'(`SSA_LAST_RESULT_BIT - q.cnt);
        addr_next     = {q.addr[`SSA_MUX_W-2:0], pins.serial_input};
        d             = q;
        d.sclk_prev   = pins.sclk;
        d.sample_pos  = 1'b0;
        d.sample_neg  = 1'b0;
        d.cmp_strobe  = 1'b0;

        // Busy falls on the rising edge after the last decision
        if (q.busy && sclk_rise && q.state != SSA_CONV && q.state != SSA_SETTLE) begin
            d.busy = 1'b0;
        end

        case (q.state)
            SSA_IDLE: begin
                if (sclk_rise && pins.serial_input) begin
                    d.cnt = `SSA_ZERO_NIBBLE;
                    if (ADDR_W == 0) begin
                        d.state = SSA_SETTLE;
                    end else begin
                        d.state = SSA_ADDR;
                    end
                end
            end
            SSA_ADDR: begin
                if (sclk_rise) begin
                    d.addr = addr_next;
                    d.cnt  = 4'(q.cnt + 4'h1);
                    if (q.cnt == 4'(ADDR_W - 1)) begin
                        d.state = SSA_SETTLE;
                        d.mux   = ssa_mux_type'(4'(addr_next << (`SSA_MUX_W - ADDR_W)));
                    end
                end
            end
            SSA_SETTLE: begin
                // Serial input is no longer looked at from here on
                if (sclk_fall) begin
                    d.busy       = 1'b1;
                    d.do_en_n    = 1'b0;
                    d.do_bit     = 1'b0;
                    d.trial      = `SSA_TRIAL_START;
                    d.cnt        = `SSA_ZERO_NIBBLE;
                    d.sample_pos = 1'b1;
                    d.state      = SSA_CONV;
                end
            end
            SSA_CONV: begin
                if (sclk_rise && q.cnt == `SSA_ZERO_NIBBLE && q.trial == `SSA_TRIAL_START) begin
                    d.sample_neg = 1'b1;
                end
                if (sclk_fall) begin
                    d.cmp_strobe      = 1'b1;
                    d.do_bit          = pins.comparator_high;
                    d.trial[bit_idx]  = pins.comparator_high;
                    d.result[bit_idx] = pins.comparator_high;
                    if (bit_idx != 3'h0) begin
                        d.trial[bit_idx - 3'h1] = 1'b1;
                    end
                    d.cnt = 4'(q.cnt + 4'h1);
                    if (q.cnt == `SSA_LAST_RESULT_BIT) begin
                        d.out_sreg = {q.result[`SSA_RESULT_W-1:1], pins.comparator_high};
                        d.cnt      = `SSA_ZERO_NIBBLE;
                        if (MSB_ONLY) begin
                            d.state = SSA_DONE_LOW;
                        end else if (HAS_SE) begin
                            d.state = SSA_HOLD_LSB;
                        end else begin
                            d.state = SSA_LSB_OUT;
                        end
                    end
                end
            end
            SSA_HOLD_LSB: begin
                // The least significant bit stays valid while shift enable is high
                if (sclk_fall && !pins.lsb_order_enable_n) begin
                    d.out_sreg = {1'b0, q.out_sreg[`SSA_RESULT_W-1:1]};
                    d.do_bit   = q.out_sreg[1];
                    d.cnt      = 4'h1;
                    d.state    = SSA_LSB_OUT;
                end
            end
            SSA_LSB_OUT: begin
                if (sclk_fall) begin
                    if (q.cnt == `SSA_LSB_SHIFTS) begin
                        d.do_bit = 1'b0;
                        d.state  = SSA_DONE_LOW;
                    end else begin
                        d.out_sreg = {1'b0, q.out_sreg[`SSA_RESULT_W-1:1]};
                        d.do_bit   = q.out_sreg[1];
                        d.cnt      = 4'(q.cnt + 4'h1);
                    end
                end
            end
            SSA_DONE_LOW: begin
                if (sclk_fall) begin
                    d.do_bit = 1'b0;
                end
            end
            default: begin
                d.state = SSA_IDLE;
            end
        endcase

        // Deselect wins over everything; output returns to high impedance
        if (pins.cs_n) begin
            d.state    = SSA_IDLE;
            d.addr     = `SSA_ZERO_NIBBLE;
            d.cnt      = `SSA_ZERO_NIBBLE;
            d.busy     = 1'b0;
            d.do_bit   = 1'b0;
            d.do_en_n  = 1'b1;
            d.trial    = `SSA_ZERO_BYTE;
            d.result   = `SSA_ZERO_BYTE;
            d.out_sreg = `SSA_ZERO_BYTE;
            d.mux      = ssa_mux_type'(`SSA_ZERO_NIBBLE);
            d.sample_pos = 1'b0;
            d.sample_neg = 1'b0;
            d.cmp_strobe = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q            <= '0;
            q.state      <= SSA_IDLE;
            q.do_en_n    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from the state register
    // ------------------------------------------------------------------
    assign conversion_busy   = q.busy;
    assign serial_out_data   = q.do_bit;
    assign serial_out_en_n   = q.do_en_n;
    assign mux_assign        = q.mux;
    assign dac_trial_code    = q.trial;
    assign result_code       = q.result;
    assign sample_pos_strobe = q.sample_pos;
    assign sample_neg_strobe = q.sample_neg;
    assign comparator_strobe = q.cmp_strobe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_deselect_clears: assert property (
        pins.cs_n |=> (q.state == SSA_IDLE && !q.busy && q.result == `SSA_ZERO_BYTE))
        else $error("deselect did not clear state");

    chk_abort_release: assert property (
        (pins.cs_n && q.state != SSA_IDLE) |=> (q.do_en_n && !q.busy))
        else $error("abort did not release output and busy");

    chk_leading_zero: assert property (
        (q.state == SSA_IDLE && sclk_rise && !pins.serial_input && !pins.cs_n)
        |=> q.state == SSA_IDLE)
        else $error("leading zero taken as start");

    chk_addr_shift: assert property (
        (q.state == SSA_ADDR && sclk_rise && !pins.cs_n)
        |=> q.addr[0] == $past(pins.serial_input))
        else $error("address bit not shifted in");

    chk_settle_start: assert property (
        (q.state == SSA_SETTLE && sclk_fall && !pins.cs_n)
        |=> (q.busy && !q.do_en_n && !q.do_bit && q.sample_pos) ##1 !q.sample_pos)
        else $error("settling interval start wrong");

    chk_input_ignored: assert property (
        (q.state inside {SSA_SETTLE, SSA_CONV, SSA_HOLD_LSB, SSA_LSB_OUT, SSA_DONE_LOW}
         && !pins.cs_n) |=> $stable(q.addr))
        else $error("serial input accepted outside addressing");

    chk_conv_bit: assert property (
        (q.state == SSA_CONV && sclk_fall && !pins.cs_n)
        |=> (q.do_bit == $past(pins.comparator_high) && q.cmp_strobe))
        else $error("conversion bit not presented");

    chk_neg_after_pos: assert property (
        q.sample_neg |-> (q.state == SSA_CONV && q.cnt == `SSA_ZERO_NIBBLE))
        else $error("negative sample outside first period");

    chk_busy_drop: assert property (
        (q.busy && sclk_rise && !pins.cs_n
         && !(q.state inside {SSA_CONV, SSA_SETTLE})) |=> !q.busy)
        else $error("busy did not fall after conversion");

    chk_lsb_hold: assert property (
        (q.state == SSA_HOLD_LSB && pins.lsb_order_enable_n && !pins.cs_n)
        |=> q.do_bit == q.result[0])
        else $error("least significant bit not held");

    chk_done_low: assert property (
        (q.state == SSA_DONE_LOW && sclk_fall && !pins.cs_n) |=> !q.do_bit)
        else $error("output not low after stream");

    chk_single_msb: assert property (
        MSB_ONLY |-> !(q.state inside {SSA_HOLD_LSB, SSA_LSB_OUT}))
        else $error("single-input variant produced reversed stream");

    chk_start_taken: assert property (
        (q.state == SSA_IDLE && sclk_rise && pins.serial_input && !pins.cs_n)
        |=> q.state != SSA_IDLE)
        else $error("start bit not taken");

    chk_settle_quiet: assert property (
        (q.state == SSA_ADDR && sclk_rise && !pins.cs_n && q.cnt == 4'(ADDR_W - 1))
        |=> (q.state == SSA_SETTLE && !q.busy && q.do_en_n))
        else $error("settling interval not inserted");

    // Compared against the result word, not the shifter, so a bad load shows up
    chk_sreg_loaded: assert property (
        (q.state == SSA_CONV && sclk_fall && q.cnt == `SSA_LAST_RESULT_BIT && !pins.cs_n)
        |=> q.out_sreg == q.result)
        else $error("output shift register not loaded with result");

    chk_lsb_shift: assert property (
        (q.state == SSA_HOLD_LSB && sclk_fall && !pins.lsb_order_enable_n && !pins.cs_n)
        |=> (q.state == SSA_LSB_OUT && q.do_bit == q.result[1]))
        else $error("reversed stream did not start");

    chk_strobe_pulse: assert property (
        q.cmp_strobe |=> !q.cmp_strobe)
        else $error("comparator strobe longer than one clock");

    cov_conversion_done: cover property (
        q.state == SSA_CONV ##1 q.state != SSA_CONV && !pins.cs_n);
    cov_lsb_stream_end: cover property (
        q.state == SSA_LSB_OUT ##1 q.state == SSA_DONE_LOW);
    cov_abort_mid_conv: cover property (
        q.state == SSA_CONV && pins.cs_n);
    cov_hold_then_shift: cover property (
        q.state == SSA_HOLD_LSB ##1 q.state == SSA_LSB_OUT);
    cov_start_taken: cover property (
        q.state == SSA_IDLE ##1 q.state == SSA_ADDR);

endmodule // ssa_serial_ctrl

`default_nettype wire

/* ssa_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------------
module ssa_host_model (
    input  wire logic clk,
    input  wire logic do_line,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic di,
    output var  logic se_n
);
    // Phases kept above the 4-clk minimum so the synchroniser sees every edge
    localparam int HALF_CLKS = 6;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        di = 1'b0;
        se_n = 1'b1;
    end

    // Select held over the whole sequence; a new one starts with a fall
    task automatic select(input logic level);
        @(negedge clk);
        cs_n = level;
        repeat (HALF_CLKS) @(negedge clk);
    endtask

    task automatic set_se(input logic level);
        @(negedge clk);
        se_n = level;
    endtask

    // Clock stands low between bits; data set up one clk before the rise
    task automatic clock_bit(input logic d, output logic q);
        @(negedge clk);
        di = d;
        @(negedge clk);
        sclk = 1'b1;
        repeat (HALF_CLKS) @(negedge clk);
        sclk = 1'b0;
        repeat (HALF_CLKS) @(negedge clk);
        q = do_line;
    endtask
endmodule // ssa_host_model

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

`include "ssa_defines.svh"

module tb;
    import ssa_pkg::*;

    logic                     clk;
    logic                     reset_n;
    logic                     cs_n;
    logic                     sclk;
    logic                     di;
    logic                     se_n;
    logic                     cmp;
    logic                     busy;
    logic                     do_data;
    logic                     do_en_n;
    logic                     do_line;
    logic                     sp;
    logic                     sn;
    logic                     cstr;
    ssa_mux_type              mux;
    logic [`SSA_RESULT_W-1:0] trial;
    logic [`SSA_RESULT_W-1:0] result;
    logic [`SSA_RESULT_W-1:0] vin;
    logic [7:0]               n_pos;
    logic [7:0]               n_neg;
    logic [7:0]               n_cmp;
    int                       errors;
    int                       n_compared;

    // ------------------------------------------------------------------
    // Clock, reset, wire and comparator
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #4 clk = ~clk;

    initial begin
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
    end

    // Released line left floating so a stale value cannot pass
    assign do_line = do_en_n ? 1'bz : do_data;

    initial vin = 8'h00;
    always @(negedge clk) cmp <= (vin >= trial);

    // Pulse counters restart whenever the host deselects
    always @(posedge clk) begin
        if (cs_n !== 1'b0) begin
            n_pos <= 8'h00;
            n_neg <= 8'h00;
            n_cmp <= 8'h00;
        end else begin
            if (sp === 1'b1) n_pos <= n_pos + 8'h01;
            if (sn === 1'b1) n_neg <= n_neg + 8'h01;
            if (cstr === 1'b1) n_cmp <= n_cmp + 8'h01;
        end
    end

    ssa_host_model host_i (
        .clk     (clk),
        .do_line (do_line),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .di      (di),
        .se_n    (se_n)
    );

    ssa_serial_ctrl ssa_serial_ctrl_i (
        .clk                (clk),
        .reset_n            (reset_n),
        .chip_select_n      (cs_n),
        .serial_clk         (sclk),
        .serial_input       (di),
        .lsb_order_enable_n (se_n),
        .comparator_high    (cmp),
        .conversion_busy    (busy),
        .serial_out_data    (do_data),
        .serial_out_en_n    (do_en_n),
        .mux_assign         (mux),
        .dac_trial_code     (trial),
        .result_code        (result),
        .sample_pos_strobe  (sp),
        .sample_neg_strobe  (sn),
        .comparator_strobe  (cstr)
    );

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_cleared();
        check("do_idle", do_line, 1'bz);
        check("busy_idle", busy, 1'b0);
        check("mux_idle", mux, 4'h0);
        check("result_idle", result, 8'h00);
        check("trial_idle", trial, 8'h00);
    endtask

    // Start, address, conversion; leaves after the MSB stream
    task automatic start_conv(input logic [3:0] addr, input logic [7:0] v, input int zeros);
        logic q;
        vin = v;
        host_i.select(1'b0);
        for (int i = 0; i < zeros; i++) begin
            host_i.clock_bit(1'b0, q);
            check("do_lead", q, 1'bz);
        end
        host_i.clock_bit(1'b1, q);
        check("do_start", q, 1'bz);
        for (int i = 3; i >= 0; i--) begin
            host_i.clock_bit(addr[i], q);
            if (i > 0) check("do_addr", q, 1'bz);
        end
        check("lead_zero", q, 1'b0);
        check("busy_settle", busy, 1'b1);
        check("mux", mux, addr);
        for (int i = 7; i >= 0; i--) begin
            // Serial input held high here; it must not reach the address
            host_i.clock_bit(1'b1, q);
            check("msb_bit", q, v[i]);
        end
        check("busy_last", busy, 1'b1);
        check("result", result, v);
        check("mux_kept", mux, addr);
        check("n_pos", n_pos, 8'h01);
        check("n_neg", n_neg, 8'h01);
        check("n_cmp", n_cmp, 8'h08);
    endtask

    task automatic full_conv(input logic [3:0] addr, input logic [7:0] v, input int zeros,
                             input int holds);
        logic q;
        start_conv(addr, v, zeros);
        for (int i = 0; i < holds; i++) begin
            host_i.clock_bit(1'b0, q);
            check("lsb_hold", q, v[0]);
            if (i == 0) check("busy_done", busy, 1'b0);
        end
        host_i.set_se(1'b0);
        for (int i = 1; i < 8; i++) begin
            host_i.clock_bit(1'b0, q);
            check("lsb_bit", q, v[i]);
        end
        for (int i = 0; i < 2; i++) begin
            host_i.clock_bit(1'b0, q);
            check("do_low", q, 1'b0);
        end
        host_i.set_se(1'b1);
        host_i.select(1'b1);
        check_cleared();
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        n_compared = 0;
        @(posedge reset_n);
        repeat (4) @(negedge clk);
        check_cleared();
        full_conv(4'h8, 8'h00, 0, 1);
        full_conv(4'hF, 8'hFF, 2, 3);
        full_conv(4'h3, 8'hA5, 1, 1);
        full_conv(4'h6, 8'h5A, 3, 2);
        // Deselect after the MSB stream, then a fresh conversion must run whole
        start_conv(4'hC, 8'h81, 0);
        host_i.select(1'b1);
        check_cleared();
        full_conv(4'h1, 8'h7E, 0, 1);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule // tb

`default_nettype wire
